// ===== hdl/sprs_defines.svh
// timing and register constants for the sensor power and reset sequencer
`ifndef SPRS_DEFINES_SVH
`define SPRS_DEFINES_SVH

`define SPRS_CLK_MHZ 100
`define SPRS_TMR_W 24
`define SPRS_STEP_US 5
`define SPRS_RST_HOLD_US 1000
`define SPRS_INIT_REFCLKS 150000
`define SPRS_PLL_LOCK_US 1000
`define SPRS_OFF_MS 100
`define SPRS_MS_US 1000
`define SPRS_REF_DIV 4
`define SPRS_REF_HALF 2'h1
`define SPRS_CTRL_ADDR 16'h301a
`define SPRS_STREAM_MASK 16'h0004
`define SPRS_STREAM_OFF 16'h0000

`endif

// ===== hdl/sprs_pkg.sv
// types shared by the sensor power and reset sequencer modules
package sprs_pkg;

  // supply enables, one bit per rail group
  typedef struct packed {
    logic serial; // serial output supply
    logic io;     // i/o supply
    logic core;   // core supply
    logic ana;    // analog and pixel supplies
    logic pll;    // pll supply
  } sprs_supply_t;

  // register write request toward the serial control agent
  typedef struct packed {
    logic valid;       // held until acknowledged
    logic [15:0] addr; // register address
    logic [15:0] mask; // bits to be modified
    logic [15:0] data; // new value of the masked bits
  } sprs_wr_t;

  // sequencer states
  typedef enum logic [4:0] {
    S_IDLE, S_UP_ANA, S_UP_CORE, S_UP_IO, S_UP_SER, S_CLK, S_RST, S_INIT,
    S_CFG, S_LOCK, S_WR_ON, S_STREAM, S_WR_OFF, S_WAIT_SB,
    S_PD_SER, S_PD_IO, S_PD_CORE, S_PD_ANA, S_PD_PLL, S_OFF
  } sprs_state_t;

  // interval timer state
  typedef struct packed {
    logic [23:0] cnt; // cycles left
    logic done;       // interval over
  } sprs_tmr_t;

  // reference clock divider state
  typedef struct packed {
    logic [1:0] ph; // phase count
    logic clk;      // divided clock
  } sprs_div_t;

  // whole state of the sequencer
  typedef struct packed {
    sprs_state_t st;    // sequence step
    logic tmr_start;    // one-cycle timer load
    logic [23:0] tmr_val; // interval to load
    sprs_supply_t sup;  // supply enables
    logic refclk_en;    // reference clock running
    logic rst_n;        // sensor reset line, active low
    sprs_wr_t wr;       // control register write
    logic cfg_ready;    // sensor in standby, ready for setup
    logic streaming;    // streaming enabled
    logic powered;      // a power cycle is under way
  } sprs_seq_t;

endpackage : sprs_pkg

// ===== hdl/sprs_timer.sv
// loadable down-counting interval timer
`timescale 1ns/100ps
`default_nettype none
`include "sprs_defines.svh"

module sprs_timer (
  input wire logic clk,                      // system clock
  input wire logic rstn,                     // async reset, active low
  input wire logic start,                    // load pulse
  input wire logic [`SPRS_TMR_W-1:0] count,  // interval in cycles, at least one
  output logic done                          // high once the interval is over
);

  sprs_pkg::sprs_tmr_t t_ff; // registered state
  sprs_pkg::sprs_tmr_t nxt_t; // next state

  // load on start, count down, flag the last cycle
  always_comb begin
    nxt_t = t_ff;
    if (start) begin
      nxt_t.cnt = count;
      nxt_t.done = 1'b0;
    end else if (!t_ff.done) begin
      nxt_t.cnt = t_ff.cnt - 24'h1;
      if (t_ff.cnt <= 24'h1) begin
        nxt_t.done = 1'b1;
      end
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      t_ff <= '{cnt: 24'h0, done: 1'b1};
    end else begin
      t_ff <= nxt_t;
    end
  end

  assign done = t_ff.done;

endmodule : sprs_timer
`default_nettype wire

// ===== hdl/sprs_refclk.sv
// gated divider that makes the sensor reference clock
`timescale 1ns/100ps
`default_nettype none
`include "sprs_defines.svh"

module sprs_refclk (
  input wire logic clk,   // system clock
  input wire logic rstn,  // async reset, active low
  input wire logic en,    // run the reference clock
  output logic ref_clk    // divided clock, low while stopped
);

  sprs_pkg::sprs_div_t d_ff; // registered state
  sprs_pkg::sprs_div_t nxt_d; // next state

  // toggle every half period; stop low so no runt pulse leaves
  always_comb begin
    nxt_d = d_ff;
    if (en || d_ff.clk) begin
      if (d_ff.ph == `SPRS_REF_HALF) begin
        nxt_d.ph = 2'h0;
        nxt_d.clk = !d_ff.clk;
      end else begin
        nxt_d.ph = d_ff.ph + 2'h1;
      end
    end else begin
      nxt_d.ph = 2'h0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      d_ff <= '{ph: 2'h0, clk: 1'b0};
    end else begin
      d_ff <= nxt_d;
    end
  end

  assign ref_clk = d_ff.clk;

endmodule : sprs_refclk
`default_nettype wire

// ===== hdl/sprs_seq.sv
// host-side power, clock, reset and streaming sequencer for an image sensor
// Contract
// - supplies on pll, analog, core, io spaced
// - reference clock starts after last supply
// - reset held low at least 1 ms
// - reset hold covers oscillator settling too
// - wait 150000 reference clocks after reset
// - setup done before streaming is enabled
// - wait 1 ms pll lock before streaming
// - control bit 2 set streams, clear standbys
// - clear streaming before any power down
// - supplies off serial, io, core, analog, pll
// - all supplies off 100 ms before repowering
// - io supply at least 5 us after core
`timescale 1ns/100ps
`default_nettype none
`include "sprs_defines.svh"

module sprs_seq #(
  parameter int RST_HOLD_CYC = `SPRS_RST_HOLD_US * `SPRS_CLK_MHZ,        // reset hold
  parameter int INIT_CYC = `SPRS_INIT_REFCLKS * `SPRS_REF_DIV,           // sensor init
  parameter int PLL_LOCK_CYC = `SPRS_PLL_LOCK_US * `SPRS_CLK_MHZ,        // pll lock
  parameter int OFF_CYC = `SPRS_OFF_MS * `SPRS_MS_US * `SPRS_CLK_MHZ     // off time
) (
  input wire logic clk,                      // system clock, 100 MHz
  input wire logic rstn,                     // async reset, active low
  input wire logic pwr_up_req,               // start a power-up
  input wire logic cfg_done,                 // user finished pll, output, image setup
  input wire logic pwr_dn_req,               // start a power-down
  input wire logic use_serial_supply,        // serial output supply fitted
  input wire logic wr_ack,                   // serial agent finished the write
  input wire logic standby_seen,             // sensor reached soft standby
  output sprs_pkg::sprs_supply_t sup_en,     // supply enables
  output logic input_ref_clock,              // sensor reference clock
  output logic sensor_reset_n,               // sensor hard reset, active low
  output sprs_pkg::sprs_wr_t ctrl_wr,        // sensor_control_reg write
  output logic cfg_ready,                    // setup may be done now
  output logic streaming,                    // streaming enabled
  output logic powered                       // power cycle in progress
);

  localparam int STEP_CYC = `SPRS_STEP_US * `SPRS_CLK_MHZ; // rail spacing

  sprs_pkg::sprs_seq_t s_ff; // registered state
  sprs_pkg::sprs_seq_t nxt_s; // next state
  logic tmr_done; // timer interval over
  logic tdone; // timer over and not just reloaded

  // interval timer shared by all timed steps
  sprs_timer u_tmr (
    .clk(clk),
    .rstn(rstn),
    .start(s_ff.tmr_start),
    .count(s_ff.tmr_val),
    .done(tmr_done)
  );

  // reference clock generator
  sprs_refclk u_ref (
    .clk(clk),
    .rstn(rstn),
    .en(s_ff.refclk_en),
    .ref_clk(input_ref_clock)
  );

  // timer done is stale in the cycle its load is still pending
  assign tdone = tmr_done && !s_ff.tmr_start;

  // sequence step logic
  always_comb begin
    nxt_s = s_ff;
    nxt_s.tmr_start = 1'b0;
    nxt_s.wr.valid = s_ff.wr.valid && !wr_ack;
    unique case (s_ff.st)
      // wait for a power-up request; pll rail goes first
      sprs_pkg::S_IDLE: begin
        if (pwr_up_req) begin
          nxt_s.sup.pll = 1'b1;
          nxt_s.powered = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_UP_ANA;
        end
      end
      // analog and pixel after pll
      sprs_pkg::S_UP_ANA: begin
        if (tdone) begin
          nxt_s.sup.ana = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_UP_CORE;
        end
      end
      // core after analog
      sprs_pkg::S_UP_CORE: begin
        if (tdone) begin
          nxt_s.sup.core = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_UP_IO;
        end
      end
      // io a full step after core
      sprs_pkg::S_UP_IO: begin
        if (tdone) begin
          nxt_s.sup.io = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = use_serial_supply ? sprs_pkg::S_UP_SER : sprs_pkg::S_CLK;
        end
      end
      // optional serial output rail last
      sprs_pkg::S_UP_SER: begin
        if (tdone) begin
          nxt_s.sup.serial = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_CLK;
        end
      end
      // last rail has settled: start the clock, begin the reset hold
      sprs_pkg::S_CLK: begin
        if (tdone) begin
          nxt_s.refclk_en = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(RST_HOLD_CYC);
          nxt_s.st = sprs_pkg::S_RST;
        end
      end
      // release reset after the hold
      sprs_pkg::S_RST: begin
        if (tdone) begin
          nxt_s.rst_n = 1'b1;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(INIT_CYC);
          nxt_s.st = sprs_pkg::S_INIT;
        end
      end
      // sensor initialising into soft standby
      sprs_pkg::S_INIT: begin
        if (tdone) begin
          nxt_s.cfg_ready = 1'b1;
          nxt_s.st = sprs_pkg::S_CFG;
        end
      end
      // user sets up pll, output and image over the serial port
      sprs_pkg::S_CFG: begin
        if (pwr_dn_req) begin
          nxt_s.st = sprs_pkg::S_PD_SER;
        end else if (cfg_done) begin
          nxt_s.cfg_ready = 1'b0;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(PLL_LOCK_CYC);
          nxt_s.st = sprs_pkg::S_LOCK;
        end
      end
      // pll lock wait, then set the streaming bit
      sprs_pkg::S_LOCK: begin
        if (tdone) begin
          nxt_s.wr.valid = 1'b1;
          nxt_s.wr.data = `SPRS_STREAM_MASK;
          nxt_s.st = sprs_pkg::S_WR_ON;
        end
      end
      // streaming write in flight
      sprs_pkg::S_WR_ON: begin
        if (wr_ack) begin
          nxt_s.streaming = 1'b1;
          nxt_s.st = sprs_pkg::S_STREAM;
        end
      end
      // streaming; a power-down first clears the bit
      sprs_pkg::S_STREAM: begin
        if (pwr_dn_req) begin
          nxt_s.wr.valid = 1'b1;
          nxt_s.wr.data = `SPRS_STREAM_OFF;
          nxt_s.st = sprs_pkg::S_WR_OFF;
        end
      end
      // standby request in flight
      sprs_pkg::S_WR_OFF: begin
        if (wr_ack) begin
          nxt_s.st = sprs_pkg::S_WAIT_SB;
        end
      end
      // sensor ends its row or frame before standby
      sprs_pkg::S_WAIT_SB: begin
        if (standby_seen) begin
          nxt_s.streaming = 1'b0;
          nxt_s.st = sprs_pkg::S_PD_SER;
        end
      end
      // stop clock, assert reset, drop the serial rail
      sprs_pkg::S_PD_SER: begin
        nxt_s.refclk_en = 1'b0;
        nxt_s.rst_n = 1'b0;
        nxt_s.cfg_ready = 1'b0;
        nxt_s.sup.serial = 1'b0;
        nxt_s.tmr_start = 1'b1;
        nxt_s.tmr_val = 24'(STEP_CYC);
        nxt_s.st = sprs_pkg::S_PD_IO;
      end
      // io off
      sprs_pkg::S_PD_IO: begin
        if (tdone) begin
          nxt_s.sup.io = 1'b0;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_PD_CORE;
        end
      end
      // core off
      sprs_pkg::S_PD_CORE: begin
        if (tdone) begin
          nxt_s.sup.core = 1'b0;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_PD_ANA;
        end
      end
      // analog and pixel off
      sprs_pkg::S_PD_ANA: begin
        if (tdone) begin
          nxt_s.sup.ana = 1'b0;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(STEP_CYC);
          nxt_s.st = sprs_pkg::S_PD_PLL;
        end
      end
      // pll off last, then the off time
      sprs_pkg::S_PD_PLL: begin
        if (tdone) begin
          nxt_s.sup.pll = 1'b0;
          nxt_s.tmr_start = 1'b1;
          nxt_s.tmr_val = 24'(OFF_CYC);
          nxt_s.st = sprs_pkg::S_OFF;
        end
      end
      // rails discharge before a new power-up
      sprs_pkg::S_OFF: begin
        if (tdone) begin
          nxt_s.powered = 1'b0;
          nxt_s.st = sprs_pkg::S_IDLE;
        end
      end
      // illegal code: back to idle
      default: begin
        nxt_s.st = sprs_pkg::S_IDLE;
      end
    endcase
  end

  // state register; everything off and reset asserted
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      s_ff <= '{st: sprs_pkg::S_IDLE, tmr_start: 1'b0, tmr_val: 24'h0, sup: '0, refclk_en: 1'b0,
                rst_n: 1'b0, wr: '{valid: 1'b0, addr: `SPRS_CTRL_ADDR, mask: `SPRS_STREAM_MASK,
                data: `SPRS_STREAM_OFF}, cfg_ready: 1'b0, streaming: 1'b0, powered: 1'b0};
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign sup_en = s_ff.sup;
  assign sensor_reset_n = s_ff.rst_n;
  assign ctrl_wr = s_ff.wr;
  assign cfg_ready = s_ff.cfg_ready;
  assign streaming = s_ff.streaming;
  assign powered = s_ff.powered;

  // checking helpers: reset-low time, init time, lock time, off time
  logic [31:0] rst_lo_cnt; // cycles reset low with clock enabled
  logic [31:0] since_rel_cnt; // cycles since reset release
  logic [31:0] since_cfg_cnt; // cycles since setup finished
  logic [31:0] off_cnt; // cycles with all rails off
  logic cfg_seen; // setup finished in this power cycle

  // helper counters
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rst_lo_cnt <= 32'h0;
      since_rel_cnt <= 32'h0;
      since_cfg_cnt <= 32'h0;
      off_cnt <= 32'hffffffff;
      cfg_seen <= 1'b0;
    end else begin
      rst_lo_cnt <= (!s_ff.rst_n && s_ff.refclk_en) ? rst_lo_cnt + 32'h1 : 32'h0;
      since_rel_cnt <= s_ff.rst_n ? since_rel_cnt + 32'h1 : 32'h0;
      since_cfg_cnt <= cfg_seen ? since_cfg_cnt + 32'h1 : 32'h0;
      if (s_ff.sup != '0) begin
        off_cnt <= 32'h0;
      end else if (off_cnt != 32'hffffffff) begin
        off_cnt <= off_cnt + 32'h1;
      end
      if (s_ff.st == sprs_pkg::S_CFG && cfg_done && !pwr_dn_req) begin
        cfg_seen <= 1'b1;
      end else if (!s_ff.rst_n) begin
        cfg_seen <= 1'b0;
      end
    end
  end

  a_pll_first_up: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sup_en.ana) |-> sup_en.pll && $past(sup_en.pll, 400)) else $error("analog rail before pll rail");
  a_core_io_gap: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sup_en.io) |-> $past(sup_en.core, 400) && sup_en.ana) else $error("io rail too soon after core");
  a_clk_after_rails: assert property (@(posedge clk) disable iff (!rstn)
    input_ref_clock |-> sup_en.pll && sup_en.ana && sup_en.core && sup_en.io) else $error("clock without rails");
  a_reset_hold_time: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sensor_reset_n) |-> $past(rst_lo_cnt) >= 32'(RST_HOLD_CYC)) else $error("reset released too early");
  a_init_wait_time: assert property (@(posedge clk) disable iff (!rstn)
    $rose(cfg_ready) |-> sensor_reset_n && since_rel_cnt >= 32'(INIT_CYC)) else $error("setup offered too early");
  a_stream_needs_cfg: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ctrl_wr.valid) && ctrl_wr.data == `SPRS_STREAM_MASK |-> cfg_seen) else $error("streaming before setup");
  a_pll_lock_wait: assert property (@(posedge clk) disable iff (!rstn)
    $rose(ctrl_wr.valid) && ctrl_wr.data == `SPRS_STREAM_MASK |-> since_cfg_cnt >= 32'(PLL_LOCK_CYC))
    else $error("streaming before pll lock");
  a_wr_held_ack: assert property (@(posedge clk) disable iff (!rstn)
    ctrl_wr.valid && !wr_ack |=> ctrl_wr.valid && $stable(ctrl_wr.data)) else $error("write dropped before ack");
  a_stream_off_first: assert property (@(posedge clk) disable iff (!rstn)
    $fell(sup_en.io) |-> !streaming && !input_ref_clock) else $error("power-down while streaming");
  a_pd_order: assert property (@(posedge clk) disable iff (!rstn)
    ($fell(sup_en.pll) |-> !sup_en.ana) and ($fell(sup_en.ana) |-> !sup_en.core) and
    ($fell(sup_en.core) |-> !sup_en.io) and ($fell(sup_en.io) |-> !sup_en.serial)) else $error("power-down order");
  a_off_time: assert property (@(posedge clk) disable iff (!rstn)
    $rose(sup_en.pll) |-> $past(off_cnt) >= 32'(OFF_CYC)) else $error("repowered too soon");
  a_reset_low_off: assert property (@(posedge clk) disable iff (!rstn)
    !sup_en.io |-> !sensor_reset_n) else $error("reset high without rails");

endmodule : sprs_seq
`default_nettype wire

// ===== dv/sprs_sensor_model.sv
// behavioural image sensor with its serial control agent, facing the sequencer
`timescale 1ns/100ps
`default_nettype none
`include "sprs_defines.svh"

module sprs_sensor_model #(
  parameter int INIT_REFCLKS = 10, // reference clocks of internal start-up
  parameter int ACK_DLY = 3,       // serial write latency in cycles, less one
  parameter int ROW_CYC = 30       // system cycles in one row
) (
  input wire logic clk,                     // system clock
  input wire logic rstn,                    // async reset, active low
  input wire sprs_pkg::sprs_supply_t sup_en, // supply enables
  input wire logic input_ref_clock,         // reference clock from the host
  input wire logic sensor_reset_n,          // hard reset, active low
  input wire sprs_pkg::sprs_wr_t ctrl_wr,   // control register write
  output logic wr_ack,                      // write done pulse
  output logic standby_seen,                // soft standby reached
  output logic init_done,                   // internal start-up over
  output logic stream_bit                   // streaming bit of sensor_control_reg
);
  logic ref_q;             // last reference clock level
  int ref_cnt;             // reference clocks since reset release
  int ack_cnt;             // serial write latency count
  int row_cnt;             // position within the current row
  logic active;            // rows being read out
  logic [15:0] ctrl_reg;   // sensor_control_reg

  assign init_done = (ref_cnt == INIT_REFCLKS);
  assign stream_bit = ctrl_reg[2];
  assign standby_seen = init_done && !active && !ctrl_reg[2];

  // start-up counter, serial agent and row readout
  always @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      ref_q <= 1'b0;
      ref_cnt <= 0;
      ack_cnt <= 0;
      row_cnt <= 0;
      active <= 1'b0;
      wr_ack <= 1'b0;
      ctrl_reg <= 16'h0000;
    end else begin
      ref_q <= input_ref_clock;
      wr_ack <= 1'b0;
      // hard reset or a dead core rail restarts initialisation
      if (!sensor_reset_n || !sup_en.core) begin
        ref_cnt <= 0;
        ctrl_reg <= 16'h0000;
      end else if (input_ref_clock && !ref_q && ref_cnt < INIT_REFCLKS) begin
        ref_cnt <= ref_cnt + 1;
      end
      // masked write after a fixed latency, ignored before start-up ends
      if (ctrl_wr.valid && !wr_ack) begin
        if (ack_cnt == ACK_DLY) begin
          ack_cnt <= 0;
          wr_ack <= 1'b1;
          if (ctrl_wr.addr === `SPRS_CTRL_ADDR && init_done) begin
            ctrl_reg <= (ctrl_reg & ~ctrl_wr.mask) | (ctrl_wr.data & ctrl_wr.mask);
          end
        end else begin
          ack_cnt <= ack_cnt + 1;
        end
      end
      // row timer runs while rows are read out
      if (active) begin
        row_cnt <= (row_cnt == ROW_CYC - 1) ? 0 : row_cnt + 1;
      end
      // readout stops only at the end of a row
      if (ctrl_reg[2]) begin
        active <= 1'b1;
      end else if (row_cnt == ROW_CYC - 1) begin
        active <= 1'b0;
      end
    end
  end
endmodule : sprs_sensor_model
`default_nettype wire

// ===== dv/sensor_power_reset_sequencer_bench.sv
// self-checking bench for the sensor power and reset sequencer
`timescale 1ns/100ps
`default_nettype none

module sensor_power_reset_sequencer_bench;
  localparam int RST = 20;  // shortened reset hold
  localparam int INIT = 40; // shortened start-up wait
  localparam int LOCK = 20; // shortened pll lock wait
  localparam int OFF = 50;  // shortened off time
  localparam int STEP = 500; // rail spacing, 5 us of system cycles
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic pwr_up_req = 1'b0;
  logic cfg_done = 1'b0;
  logic pwr_dn_req = 1'b0;
  logic use_serial_supply = 1'b0;
  logic wr_ack;
  logic standby_seen;
  logic init_done;
  logic stream_bit;
  sprs_pkg::sprs_supply_t sup_en;
  sprs_pkg::sprs_wr_t ctrl_wr;
  logic input_ref_clock;
  logic sensor_reset_n;
  logic cfg_ready;
  logic streaming;
  logic powered;
  int miscompares = 0; // mismatches seen
  int total_checks = 0; // comparisons made
  int cyc = 0;         // system cycle count
  int ref_edges = 0;   // reference clock rises
  int first_ref = -1;  // cycle of first reference clock rise

  // 100 MHz system clock
  always #5 clk = ~clk;
  // cycle counter
  always @(posedge clk) cyc++;
  // reference clock watcher
  always @(posedge input_ref_clock) begin
    ref_edges++;
    if (first_ref < 0) first_ref = cyc;
  end

  sprs_seq #(.RST_HOLD_CYC(RST), .INIT_CYC(INIT), .PLL_LOCK_CYC(LOCK), .OFF_CYC(OFF)) u_dut (
    .clk(clk), .rstn(rstn), .pwr_up_req(pwr_up_req), .cfg_done(cfg_done), .pwr_dn_req(pwr_dn_req),
    .use_serial_supply(use_serial_supply), .wr_ack(wr_ack), .standby_seen(standby_seen),
    .sup_en(sup_en), .input_ref_clock(input_ref_clock), .sensor_reset_n(sensor_reset_n),
    .ctrl_wr(ctrl_wr), .cfg_ready(cfg_ready), .streaming(streaming), .powered(powered)
  );

  sprs_sensor_model #(.INIT_REFCLKS(INIT / 4)) u_sensor (
    .clk(clk), .rstn(rstn), .sup_en(sup_en), .input_ref_clock(input_ref_clock),
    .sensor_reset_n(sensor_reset_n), .ctrl_wr(ctrl_wr), .wr_ack(wr_ack),
    .standby_seen(standby_seen), .init_done(init_done), .stream_bit(stream_bit)
  );

  // verdict and end of run
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : wrap_up

  // one cycle, sampled after the edge settles
  task automatic tick();
    @(posedge clk);
    #1;
  endtask : tick

  // exact value comparison
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : check

  // cycle count comparison against a window
  task automatic rng(input string what, input int lo, input int hi, input int got);
    total_checks++;
    if (got < lo || got > hi) begin
      miscompares++;
      $display("FAIL %s expected %0d..%0d seen %0d", what, lo, hi, got);
    end
  endtask : rng

  // pick a watched output
  function automatic logic sel(input int k);
    case (k)
      0: sel = sensor_reset_n;
      1: sel = cfg_ready;
      2: sel = ctrl_wr.valid;
      3: sel = streaming;
      default: sel = powered;
    endcase
  endfunction : sel

  // bounded wait for an output level
  task automatic wait_bit(input int k, input logic v, output int n);
    n = 0;
    while (sel(k) !== v && n < 3000) begin
      tick();
      n++;
    end
    if (n >= 3000) begin
      miscompares++;
      $display("FAIL output %0d expected %b seen timeout", k, v);
      wrap_up();
    end
  endtask : wait_bit

  // bounded wait for the next supply step
  task automatic rail(input logic [4:0] exp, input int lo, input int hi);
    logic [4:0] prev;
    int n;
    prev = sup_en;
    n = 0;
    while (sup_en === prev && n < 3000) begin
      tick();
      n++;
    end
    check("sup_en", {11'h0, exp}, {11'h0, sup_en});
    rng("rail spacing", lo, hi, n);
    if (n >= 3000) wrap_up();
  endtask : rail

  // outputs quiet while reset is held
  task automatic t_reset();
    check("sup_en", 16'h0000, {11'h0, sup_en});
    check("reset line", 16'h0000, {15'h0, sensor_reset_n});
    check("quiet outs", 16'h0000, {11'h0, input_ref_clock, ctrl_wr.valid, cfg_ready, streaming, powered});
    $display("test reset done");
  endtask : t_reset

  // power-up with a power-down request held and refused
  task automatic t_power_up(input logic ser);
    int n;
    int t_rel;
    int t_sup;
    ref_edges = 0;
    first_ref = -1;
    @(posedge clk);
    pwr_up_req <= 1'b1;
    pwr_dn_req <= 1'b1;
    use_serial_supply <= ser;
    @(posedge clk);
    pwr_up_req <= 1'b0;
    #1;
    check("pll first", 16'h0001, {11'h0, sup_en});
    check("powered", 16'h0001, {15'h0, powered});
    rail(5'h03, 400, 1000);
    rail(5'h07, 400, 1000);
    rail(5'h0f, 500, 1000);
    if (ser) rail(5'h1f, 0, 1000);
    t_sup = cyc;
    check("clock before rails", 16'h0000, ref_edges[15:0]);
    @(posedge clk);
    pwr_dn_req <= 1'b0;
    wait_bit(0, 1'b1, n);
    t_rel = cyc;
    rng("reset hold", RST, STEP + RST + 20, t_rel - t_sup);
    rng("clock before release", 1, RST + 20, t_rel - first_ref);
    wait_bit(1, 1'b1, n);
    check("sensor init", 16'h0001, {15'h0, init_done});
    rng("init wait", INIT - 2, INIT + 10, n);
    check("no early write", 16'h0000, {15'h0, ctrl_wr.valid});
    $display("test power_up done");
  endtask : t_power_up

  // setup done, pll lock wait, streaming write
  task automatic t_stream_on();
    int n;
    @(posedge clk);
    cfg_done <= 1'b1;
    @(posedge clk);
    cfg_done <= 1'b0;
    #1;
    check("cfg_ready fall", 16'h0000, {15'h0, cfg_ready});
    wait_bit(2, 1'b1, n);
    rng("pll lock wait", LOCK, LOCK + 10, n);
    check("wr addr", 16'h301a, ctrl_wr.addr);
    check("wr mask", 16'h0004, ctrl_wr.mask);
    check("wr data", 16'h0004, ctrl_wr.data);
    wait_bit(3, 1'b1, n);
    rng("ack to streaming", 0, 10, n);
    check("sensor streams", 16'h0001, {15'h0, stream_bit});
    $display("test stream_on done");
  endtask : t_stream_on

  // power-down, then off time with a refused power-up
  task automatic t_power_down(input logic from_stream);
    int n;
    @(posedge clk);
    pwr_dn_req <= 1'b1;
    @(posedge clk);
    pwr_dn_req <= 1'b0;
    #1;
    check("stop write", {15'h0, from_stream}, {15'h0, ctrl_wr.valid});
    if (from_stream) begin
      check("stop data", 16'h0000, ctrl_wr.data);
      wait_bit(3, 1'b0, n);
      check("row ended", 16'h0001, {15'h0, standby_seen});
      check("reset still high", 16'h0001, {15'h0, sensor_reset_n});
      check("sensor standby", 16'h0000, {15'h0, stream_bit});
    end
    wait_bit(0, 1'b0, n);
    check("serial off first", 16'h000f, {11'h0, sup_en});
    rail(5'h07, 0, 1000);
    rail(5'h03, 0, 1000);
    rail(5'h01, 0, 1000);
    rail(5'h00, 0, 1000);
    @(posedge clk);
    pwr_up_req <= 1'b1;
    @(posedge clk);
    pwr_up_req <= 1'b0;
    wait_bit(4, 1'b0, n);
    rng("off time", OFF - 4, OFF + 10, n);
    tick();
    tick();
    check("early power-up refused", 16'h0000, {11'h0, sup_en});
    $display("test power_down done");
  endtask : t_power_down

  // main sequence
  initial begin
    repeat (20) @(posedge clk);
    t_reset();
    @(posedge clk);
    rstn <= 1'b1;
    t_power_up(1'b0);
    t_stream_on();
    t_power_down(1'b1);
    t_power_up(1'b1);
    t_power_down(1'b0);
    wrap_up();
  end
endmodule : sensor_power_reset_sequencer_bench
`default_nettype wire
